// *** rtl/updsc_pkg.sv ***
// Shared constants and types of the port drive and data pin swap settings bank.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.
package updsc_pkg;

   // Register indices; each register sits in one aligned word at four times its index.
   localparam logic [7:0] UPDSC_UP_IDX = 8'hEF;
   localparam logic [7:0] UPDSC_DN_IDX = 8'hF0;
   localparam logic [7:0] UPDSC_SW_IDX = 8'hF1;

   // Byte addresses derived from the indices.
   localparam logic [11:0] UPDSC_UP_ADDR = {2'h0, UPDSC_UP_IDX, 2'h0};
   localparam logic [11:0] UPDSC_DN_ADDR = {2'h0, UPDSC_DN_IDX, 2'h0};
   localparam logic [11:0] UPDSC_SW_ADDR = {2'h0, UPDSC_SW_IDX, 2'h0};

   // Implemented bits of each register; all other bits are reserved.
   localparam logic [7:0] UPDSC_UP_MASK = 8'h03;
   localparam logic [7:0] UPDSC_DN_MASK = 8'h3C;
   localparam logic [7:0] UPDSC_SW_MASK = 8'h0D;

   // Field positions.
   localparam int UPDSC_UP_LSB = 0;
   localparam int UPDSC_P2_LSB = 2;
   localparam int UPDSC_P3_LSB = 4;
   localparam int UPDSC_SW_P0 = 0;
   localparam int UPDSC_SW_P2 = 2;
   localparam int UPDSC_SW_P3 = 3;

   // Reset values of the three registers.
   localparam logic [7:0] UPDSC_UP_RST = 8'h00;
   localparam logic [7:0] UPDSC_DN_RST = 8'h00;
   localparam logic [7:0] UPDSC_SW_RST = 8'h00;

   // Bus response codes.
   localparam logic [1:0] UPDSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] UPDSC_RESP_SLVERR = 2'h2;

   // Register selection codes produced by the address decoder.
   localparam logic [1:0] UPDSC_SEL_UP = 2'h0;
   localparam logic [1:0] UPDSC_SEL_DN = 2'h1;
   localparam logic [1:0] UPDSC_SEL_SW = 2'h2;
   localparam logic [1:0] UPDSC_SEL_NONE = 2'h3;

   // Number of ports with a swappable data pin pair.
   localparam int UPDSC_NPORT = 3;

   // Drive boost level of one port transceiver.
   typedef enum logic [1:0] {
      UPDSC_BOOST_NONE = 2'h0,
      UPDSC_BOOST_LOW = 2'h1,
      UPDSC_BOOST_MED = 2'h2,
      UPDSC_BOOST_HIGH = 2'h3
   } updsc_boost_type;

endpackage

// *** rtl/updsc_pin_swap.sv ***
// One port's data pin role multiplexer with synchronised pin inputs.
// Assumes transceiver signals are on aclk and the pins come from outside the domain.
module updsc_pin_swap (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic swap,
   input wire logic xcvr_dp_out,
   input wire logic xcvr_dm_out,
   input wire logic xcvr_oe_n,
   output logic xcvr_dp_in,
   output logic xcvr_dm_in,
   input wire logic pin_dp_i,
   input wire logic pin_dm_i,
   output logic pin_dp_o,
   output logic pin_dm_o,
   output logic pin_dp_oe_n,
   output logic pin_dm_oe_n
);
   import updsc_pkg::*;

   logic dp_meta_r;
   logic dm_meta_r;
   logic dp_sync_r;
   logic dm_sync_r;

   // Two-stage synchronisers; only the second stage is looked at.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_meta_r <= 1'b0;
         dm_meta_r <= 1'b0;
         dp_sync_r <= 1'b0;
         dm_sync_r <= 1'b0;
      end else begin
         dp_meta_r <= pin_dp_i;
         dm_meta_r <= pin_dm_i;
         dp_sync_r <= dp_meta_r;
         dm_sync_r <= dm_meta_r;
      end
   end

   // Outbound path: with swap set the positive line leaves on the DM pin.
   // Registering it costs a cycle but keeps the pins glitch free while swap changes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_dp_o <= 1'b0;
         pin_dm_o <= 1'b0;
         pin_dp_oe_n <= 1'b1;
         pin_dm_oe_n <= 1'b1;
      end else begin
         pin_dp_o <= swap ? xcvr_dm_out : xcvr_dp_out; // [RULE_06]
         pin_dm_o <= swap ? xcvr_dp_out : xcvr_dm_out; // [RULE_06]
         pin_dp_oe_n <= xcvr_oe_n;
         pin_dm_oe_n <= xcvr_oe_n;
      end
   end

   // Inbound path mirrors the outbound routing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xcvr_dp_in <= 1'b0;
         xcvr_dm_in <= 1'b0;
      end else begin
         xcvr_dp_in <= swap ? dm_sync_r : dp_sync_r; // [RULE_06]
         xcvr_dm_in <= swap ? dp_sync_r : dm_sync_r; // [RULE_06]
      end
   end

   // The edge that releases reset still loads reset values, so it starts no check.
   swap_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
      aresetn |=> (pin_dp_o == ($past(swap) ? $past(xcvr_dm_out) : $past(xcvr_dp_out))))
      else $error("DP pin output does not follow the swap setting.");

   swap_in_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
      aresetn |=> (xcvr_dp_in == ($past(swap) ? $past(dm_sync_r) : $past(dp_sync_r))))
      else $error("Positive line input does not follow the swap setting.");

endmodule

// *** rtl/updsc_top.sv ***
// Port drive boost and data pin swap settings bank behind an AXI4-Lite slave.
// Assumes one 100 MHz clock, synchronous active-low reset, and a single
// outstanding read and write from the bus master.
//
// Overview of operation
// RULE_01: Upstream boost field bits 1:0 sets upstream drive.
// RULE_02: Downstream register bits 5:4 set port 3 drive.
// RULE_03: Downstream register bits 3:2 set port 2 drive.
// RULE_04: Software should keep boost fields at no boost.
// RULE_05: Pin swap applies to upstream and downstream ports.
// RULE_06: Swap bit one exchanges positive and negative pins.
// RULE_07: Swap bits 3, 2, 0 control ports 3, 2, 0.
// RULE_08: Reserved bits ignored on write, read as zero.
module updsc_top #(
   parameter int AXI_AW = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output updsc_pkg::updsc_boost_type upstream_drive_level,
   output updsc_pkg::updsc_boost_type port2_drive_level,
   output updsc_pkg::updsc_boost_type port3_drive_level,
   output logic [3:0] pin_role_swap_bits,
   input wire logic [updsc_pkg::UPDSC_NPORT-1:0] xcvr_dp_out,
   input wire logic [updsc_pkg::UPDSC_NPORT-1:0] xcvr_dm_out,
   input wire logic [updsc_pkg::UPDSC_NPORT-1:0] xcvr_oe_n,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] xcvr_dp_in,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] xcvr_dm_in,
   input wire logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dp_i,
   input wire logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dm_i,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dp_o,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dm_o,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dp_oe_n,
   output logic [updsc_pkg::UPDSC_NPORT-1:0] pin_dm_oe_n
);
   import updsc_pkg::*;

   // The decoder needs ten address bits to reach the highest register.
   // The width is refused at elaboration, before any logic is built around it.
   if (AXI_AW < 10 || AXI_AW > 32) begin : g_bad_aw
      $error("AXI_AW must lie between 10 and 32.");
   end

   // Map a byte address onto a register selection; the two low bits are ignored
   // because every register occupies one aligned word.
   function automatic logic [1:0] reg_sel(input logic [31:0] a);
      logic [1:0] s;
      s = UPDSC_SEL_NONE;
      if (a[31:2] == 30'(UPDSC_UP_IDX)) begin
         s = UPDSC_SEL_UP;
      end else if (a[31:2] == 30'(UPDSC_DN_IDX)) begin
         s = UPDSC_SEL_DN;
      end else if (a[31:2] == 30'(UPDSC_SW_IDX)) begin
         s = UPDSC_SEL_SW;
      end
      return s;
   endfunction

   // Write channel state.
   logic aw_got_r;
   logic w_got_r;
   logic [AXI_AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [1:0] wr_sel;
   logic [7:0] wr_byte;
   logic wr_lane;

   // Settings registers; only implemented bits are stored.
   logic [1:0] up_lvl_r;
   logic [1:0] p2_lvl_r;
   logic [1:0] p3_lvl_r;
   logic [3:0] swap_r;

   // Read channel state.
   logic ar_take;
   logic [1:0] rd_sel;
   logic [7:0] rd_byte;

   // Handshake terms and the effective write address and data, taken either
   // from the held copy or straight from the bus in the cycle of acceptance.
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_fire = (aw_got_r || aw_take) && (w_got_r || w_take) && !s_axi_bvalid;
   assign wr_sel = reg_sel(32'(aw_got_r ? awaddr_r : s_axi_awaddr));
   assign wr_byte = w_got_r ? wdata_r[7:0] : s_axi_wdata[7:0];
   assign wr_lane = w_got_r ? wstrb_r[0] : s_axi_wstrb[0];

   // Write address channel; ready drops once an address is held and returns
   // only after the response has been taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         awaddr_r <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end else begin
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         aw_got_r <= wr_fire ? 1'b0 : (aw_got_r || aw_take);
      end
   end

   // Write data channel, independent of the address so either may come first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end else begin
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         w_got_r <= wr_fire ? 1'b0 : (w_got_r || w_take);
      end
   end

   // Write response; an address outside the bank is refused with SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= UPDSC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == UPDSC_SEL_NONE) ? UPDSC_RESP_SLVERR : UPDSC_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Settings storage. Only byte lane 0 carries data; reserved bits are
   // dropped so that later use of them cannot be disturbed by stale writes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_lvl_r <= UPDSC_UP_RST[UPDSC_UP_LSB +: 2];
         p2_lvl_r <= UPDSC_DN_RST[UPDSC_P2_LSB +: 2];
         p3_lvl_r <= UPDSC_DN_RST[UPDSC_P3_LSB +: 2];
         swap_r <= UPDSC_SW_RST[3:0] & UPDSC_SW_MASK[3:0];
      end else if (wr_fire && wr_lane) begin
         case (wr_sel)
            UPDSC_SEL_UP: begin
               up_lvl_r <= wr_byte[UPDSC_UP_LSB +: 2]; // [RULE_01]
            end
            UPDSC_SEL_DN: begin
               p3_lvl_r <= wr_byte[UPDSC_P3_LSB +: 2]; // [RULE_02]
               p2_lvl_r <= wr_byte[UPDSC_P2_LSB +: 2]; // [RULE_03]
            end
            UPDSC_SEL_SW: begin
               swap_r <= wr_byte[3:0] & UPDSC_SW_MASK[3:0]; // [RULE_07] [RULE_08]
            end
            default: begin
            end
         endcase
      end
   end

   // Settings drive the transceivers directly from their flip-flops.
   always_comb begin
      upstream_drive_level = updsc_boost_type'(up_lvl_r); // [RULE_01]
      port2_drive_level = updsc_boost_type'(p2_lvl_r); // [RULE_03]
      port3_drive_level = updsc_boost_type'(p3_lvl_r); // [RULE_02]
      pin_role_swap_bits = swap_r;
   end

   // Read data assembly; reserved and upper bits read as zero.
   assign rd_sel = reg_sel(32'(s_axi_araddr));
   always_comb begin
      rd_byte = 8'h00;
      case (rd_sel)
         UPDSC_SEL_UP: rd_byte = {6'h00, up_lvl_r}; // [RULE_08]
         UPDSC_SEL_DN: rd_byte = {2'h0, p3_lvl_r, p2_lvl_r, 2'h0}; // [RULE_08]
         UPDSC_SEL_SW: rd_byte = {4'h0, swap_r}; // [RULE_08]
         default: rd_byte = 8'h00;
      endcase
   end

   // Read channel: the answer is registered one cycle after the address.
   assign ar_take = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= UPDSC_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= (rd_sel == UPDSC_SEL_NONE) ? UPDSC_RESP_SLVERR : UPDSC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // One pin multiplexer per swappable port: index 0 is the upstream port,
   // indices 1 and 2 are downstream ports 2 and 3.
   localparam int SWAP_BIT [UPDSC_NPORT] = '{UPDSC_SW_P0, UPDSC_SW_P2, UPDSC_SW_P3};
   for (genvar i = 0; i < UPDSC_NPORT; i++) begin : g_port
      updsc_pin_swap u_swap (
         .aclk(aclk),
         .aresetn(aresetn),
         .swap(swap_r[SWAP_BIT[i]]), // [RULE_05] [RULE_07]
         .xcvr_dp_out(xcvr_dp_out[i]),
         .xcvr_dm_out(xcvr_dm_out[i]),
         .xcvr_oe_n(xcvr_oe_n[i]),
         .xcvr_dp_in(xcvr_dp_in[i]),
         .xcvr_dm_in(xcvr_dm_in[i]),
         .pin_dp_i(pin_dp_i[i]),
         .pin_dm_i(pin_dm_i[i]),
         .pin_dp_o(pin_dp_o[i]),
         .pin_dm_o(pin_dm_o[i]),
         .pin_dp_oe_n(pin_dp_oe_n[i]),
         .pin_dm_oe_n(pin_dm_oe_n[i])
      );
   end

   // Helper terms for the checks below.
   logic up_wr;
   logic dn_wr;
   logic sw_wr;
   assign up_wr = wr_fire && wr_lane && (wr_sel == UPDSC_SEL_UP);
   assign dn_wr = wr_fire && wr_lane && (wr_sel == UPDSC_SEL_DN);
   assign sw_wr = wr_fire && wr_lane && (wr_sel == UPDSC_SEL_SW);

   up_boost_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
      up_wr |=> ({6'h00, upstream_drive_level} == ($past(wr_byte) & UPDSC_UP_MASK)))
      else $error("Upstream drive level not taken from bits 1:0.");

   p3_boost_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
      dn_wr |=> ({2'h0, port3_drive_level, 4'h0} == ($past(wr_byte) & 8'h30)))
      else $error("Port 3 drive level not taken from bits 5:4.");

   p2_boost_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
      dn_wr |=> ({4'h0, port2_drive_level, 2'h0} == ($past(wr_byte) & 8'h0C)))
      else $error("Port 2 drive level not taken from bits 3:2.");

   swap_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
      sw_wr |=> ({4'h0, pin_role_swap_bits} == ($past(wr_byte) & UPDSC_SW_MASK)))
      else $error("Swap mask does not keep exactly bits 3, 2 and 0.");

   rsvd_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
      ar_take && (rd_sel == UPDSC_SEL_UP) |=> (s_axi_rdata == {30'h0, $past(up_lvl_r)}))
      else $error("Upstream register reads nonzero reserved bits.");

   hold_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
      !(up_wr || dn_wr || sw_wr) |=> $stable({up_lvl_r, p2_lvl_r, p3_lvl_r, swap_r}))
      else $error("Settings changed without a write.");

   port_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
      swap_r[UPDSC_SW_P3] && $stable(swap_r) |=> (pin_dp_o[2] == $past(xcvr_dm_out[2])))
      else $error("Port 3 pins not swapped by bit 3.");

   // The response comes one cycle after the write lands, with both channels closed.
   wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("Write response did not follow the write.");

   rd_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read answer did not follow the address.");

endmodule

// *** bench/updsc_host_model.sv ***
// AXI4-Lite master standing in for the loader that writes the hub settings.
// Assumes the slave shares aclk; the bench calls wr and rd one at a time.
module updsc_host_model (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   output logic rready
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus from time zero.
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // Address and data go out together; a taken channel shows inverted payload,
   // so a slave that samples late sees garbage rather than a stale match.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
   endtask

   // Read request held until taken; rready held until the answer is sampled.
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
   endtask
endmodule

// *** bench/tb_updsc_top.sv ***
// Self-checking bench of the drive boost and pin swap settings bank.
// Assumes the host model as bus master and random transceiver and pin traffic.
module tb_updsc_top;
   import updsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, r;
   logic [3:0] wstrb, swap_bits;
   logic [1:0] bresp, rresp;
   updsc_boost_type up_lvl, p2_lvl, p3_lvl;
   logic [2:0] dpo, dmo, oen, xdi, xmi, pdi, pmi, pdo, pmo, pdoe, pmoe;
   int bad_count, num_checks, cycles, seed, i, k;
   logic [33:0] exp_rq[$];
   logic [1:0] exp_bq[$];
   logic [33:0] e;
   logic [1:0] eb;
   logic [7:0] sh [3];
   logic [11:0] adr [3] = '{12'h3BC, 12'h3C0, 12'h3C4};
   logic [7:0] msk [3] = '{8'h03, 8'h3C, 8'h0D};

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   updsc_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rvalid(rvalid), .rready(rready));

   updsc_top #(.AXI_AW(12)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .upstream_drive_level(up_lvl), .port2_drive_level(p2_lvl),
      .port3_drive_level(p3_lvl), .pin_role_swap_bits(swap_bits), .xcvr_dp_out(dpo),
      .xcvr_dm_out(dmo), .xcvr_oe_n(oen), .xcvr_dp_in(xdi), .xcvr_dm_in(xmi),
      .pin_dp_i(pdi), .pin_dm_i(pmi), .pin_dp_o(pdo), .pin_dm_o(pmo),
      .pin_dp_oe_n(pdoe), .pin_dm_oe_n(pmoe));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // The run needs well under ten thousand cycles; a hang ends here.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   // Each answer on the bus is matched against the oldest note of the driver.
   always @(posedge aclk) begin
      if (aresetn && rvalid && rready) begin
         e = exp_rq.pop_front();
         check(rdata, e[31:0]);
         check({30'h0, rresp}, {30'h0, e[33:32]});
      end
      if (aresetn && bvalid && bready) begin
         eb = exp_bq.pop_front();
         check({30'h0, bresp}, {30'h0, eb});
      end
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] rs);
      exp_bq.push_back(rs);
      u_host.wr(a, d, s);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] rs);
      exp_rq.push_back({rs, x});
      u_host.rd(a);
   endtask

   // Reads all three back and compares the level and swap outputs.
   task automatic readback;
      for (int j = 0; j < 3; j++) begin
         rd(adr[j], {24'h0, sh[j]}, 2'h0);
      end
      @(negedge aclk);
      check({30'h0, up_lvl}, {30'h0, sh[0][1:0]});
      check({30'h0, p2_lvl}, {30'h0, sh[1][3:2]});
      check({30'h0, p3_lvl}, {30'h0, sh[1][5:4]});
      check({28'h0, swap_bits}, {28'h0, sh[2][3:0]});
   endtask

   // Random transceiver and pin levels held long enough to cross both ways.
   task automatic pin_step;
      logic sb;
      @(posedge aclk);
      r = $random(seed);
      dpo <= r[2:0];
      dmo <= r[5:3];
      oen <= r[8:6];
      pdi <= r[11:9];
      pmi <= r[14:12];
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      for (int p = 0; p < 3; p++) begin
         sb = sh[2][(p == 0) ? 0 : p + 1];
         check1(pdo[p], sb ? dmo[p] : dpo[p]);
         check1(pmo[p], sb ? dpo[p] : dmo[p]);
         check1(pdoe[p], oen[p]);
         check1(pmoe[p], oen[p]);
         check1(xdi[p], sb ? pmi[p] : pdi[p]);
         check1(xmi[p], sb ? pdi[p] : pmi[p]);
      end
   endtask

   initial begin
      seed = 95407;
      aresetn = 1'b0;
      {dpo, dmo, oen, pdi, pmi} = '0;
      sh = '{8'h00, 8'h00, 8'h00};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      readback();
      // Random bytes, reserved bits set too; the first four walk every code.
      for (i = 0; i < 12; i++) begin
         for (k = 0; k < 3; k++) begin
            r = $random(seed);
            if (i < 4) r[5:0] = {i[1:0], i[1:0], i[1:0]};
            wr(adr[k], r, 4'hF, 2'h0);
            sh[k] = r[7:0] & msk[k];
         end
         readback();
         pin_step();
      end
      // Lane 0 disabled leaves the register alone; odd low address bits are ignored.
      wr(adr[0], 32'hFF, 4'hE, 2'h0);
      rd(12'h3BD, {24'h0, sh[0]}, 2'h0);
      readback();
      // Unmapped words answer with an error and change nothing.
      wr(12'h3C8, 32'hFF, 4'hF, 2'h2);
      wr(12'h000, 32'hFF, 4'hF, 2'h2);
      rd(12'h3C8, 32'h0, 2'h2);
      rd(12'h3B8, 32'h0, 2'h2);
      readback();
      // Eight random swap settings, then traffic through the pins.
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         wr(adr[2], r, 4'hF, 2'h0);
         sh[2] = r[7:0] & 8'h0D;
         pin_step();
         pin_step();
      end
      // A reset in mid-run returns every setting to zero.
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      sh = '{8'h00, 8'h00, 8'h00};
      readback();
      pin_step();
      // Leave the boost fields at the compliant no-boost setting.
      wr(adr[0], 32'h0, 4'hF, 2'h0);
      wr(adr[1], 32'h0, 4'hF, 2'h0);
      readback();
      repeat (3) @(posedge aclk);
      stop_test();
   end
endmodule
